// [verilog/pdroc_pkg.sv]
// ==========================================================
// constants for the dual register output cell block
package pdroc_pkg;

  // ========================================================
  // array shape
  localparam int NUM_CELLS = 10;
  localparam int NUM_REGS  = 20;
  localparam int ADDR_W    = 8;

  // ========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_TTYPE    = 8'h04;
  localparam logic [7:0] OFS_PINCLK   = 8'h08;
  localparam logic [7:0] OFS_OUTSEL   = 8'h0C;
  localparam logic [7:0] OFS_POLARITY = 8'h10;
  localparam logic [7:0] OFS_STATE    = 8'h14;
  localparam logic [7:0] OFS_PINS     = 8'h18;
  localparam logic [7:0] OFS_OE       = 8'h1C;

  // ========================================================
  // control field positions
  localparam int CTRL_COMPAT_BIT = 0;
  localparam int CTRL_SECURE_BIT = 1;
  localparam int CTRL_READY_BIT  = 2;

  // ========================================================
  // reset values
  localparam logic [19:0] TTYPE_RST    = 20'h0_0000;
  localparam logic [19:0] PINCLK_RST   = 20'h0_0000;
  localparam logic [9:0]  OUTSEL_RST   = 10'h000;
  localparam logic [9:0]  POLARITY_RST = 10'h000;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

  // ========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int PWRUP_NS      = 1000;
  localparam int PWRUP_CYC     = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ========================================================
  // state machines
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_RESP = 2'b01
  } pdroc_apb_e;

  typedef enum logic [1:0] {
    PWR_HOLD = 2'b00,
    PWR_RUN  = 2'b01
  } pdroc_pwr_e;

endpackage : pdroc_pkg

// [verilog/pdroc_sync.sv]
`timescale 1ns/100ps
// ==========================================================
// two flop synchroniser for pin level inputs
module pdroc_sync #(
  parameter int WIDTH = 1
) (
  // system
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // data
  input  wire logic [WIDTH-1:0] d_in,
  output      logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule : pdroc_sync

// [verilog/pdroc_flop.sv]
`timescale 1ns/100ps
// ==========================================================
// one configurable register of an output logic cell
module pdroc_flop (
  // system
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // private terms
  input  wire logic sum_in,
  input  wire logic clk_term_in,
  input  wire logic areset_in,
  // shared inputs
  input  wire logic clk_pin_in,
  input  wire logic preset_in,
  input  wire logic hold_in,
  // configuration
  input  wire logic pin_clk_sel_in,
  input  wire logic toggle_sel_in,
  // state
  output      logic q_out
);

  logic clk_src;
  logic prev_reg;
  logic master_reg;
  logic rise;

  // pin clock or private clock term
  assign clk_src = pin_clk_sel_in ? clk_pin_in : clk_term_in;
  assign rise    = clk_src & ~prev_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= clk_src;
    end
  end

  // master half samples data ahead of the edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      master_reg <= 1'b0;
    end else if (areset_in || hold_in) begin
      master_reg <= 1'b0;
    end else begin
      master_reg <= sum_in;
    end
  end

  // slave half; reset beats preset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_out <= 1'b0;
    end else if (areset_in || hold_in) begin
      q_out <= 1'b0;
    end else if (rise) begin
      if (preset_in) begin
        q_out <= 1'b1;
      end else if (toggle_sel_in) begin
        q_out <= q_out ^ master_reg;
      end else begin
        q_out <= master_reg;
      end
    end
  end

  chk_areset_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    areset_in |=> (!q_out && !master_reg))
    else $error("reset term did not clear both halves");

  chk_reset_priority: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (areset_in && preset_in && rise) |=> !q_out)
    else $error("preset overrode reset term");

  chk_preset_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rise && preset_in && !areset_in && !hold_in) |=> q_out)
    else $error("preset missed at clock edge");

  chk_toggle_flips: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rise && toggle_sel_in && !preset_in && !areset_in && !hold_in)
      |=> (q_out == ($past(q_out) ^ $past(master_reg))))
    else $error("toggle register wrong");

  chk_dtype_loads: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rise && !toggle_sel_in && !preset_in && !areset_in && !hold_in)
      |=> (q_out == $past(master_reg)))
    else $error("d register wrong");

  chk_hold_no_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!rise && !areset_in && !hold_in) |=> $stable(q_out))
    else $error("register moved without its clock");

endmodule : pdroc_flop

// [verilog/pdroc_top.sv]
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
// ==========================================================
// Operation
// - each register chooses D or T behaviour on its own
// - each register clocks from its own clock term or the clock pin
// - two registers per cell, twenty total; one drives the pin
// - each register has private sum, reset and clock terms
// - all twenty register states feed back to the array
// - each pin has an input path apart from register feedback
// - each pin driver is enabled by its own term
// - one shared preset sets all registers at their clock edge
// - each register has its own reset term, independent of its clock
// - reset term clears both master and slave halves
// - once secured, type, clock source, output select and polarity settings read back as all ones
// - compatibility mode removes toggle registers and pin clocking
// - after power-up delay all registers are low
module pdroc_top
  import pdroc_pkg::*;
(
  // system
  input  wire logic                         sys_clk_in,
  input  wire logic                         rst_n_in,
  // apb slave
  input  wire logic [pdroc_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [31:0]                  pwdata_in,
  output      logic [31:0]                  prdata_out,
  output      logic                         pready_out,
  output      logic                         pslverr_out,
  // array terms
  input  wire logic [pdroc_pkg::NUM_REGS-1:0]  sum_term_in,
  input  wire logic [pdroc_pkg::NUM_REGS-1:0]  clk_term_in,
  input  wire logic [pdroc_pkg::NUM_REGS-1:0]  rst_term_in,
  input  wire logic                            preset_term_in,
  input  wire logic                            clk_pin_in,
  input  wire logic [pdroc_pkg::NUM_CELLS-1:0] oe_term_in,
  // io pins
  input  wire logic [pdroc_pkg::NUM_CELLS-1:0] io_pin_in,
  output      logic [pdroc_pkg::NUM_CELLS-1:0] io_pin_out,
  output      logic [pdroc_pkg::NUM_CELLS-1:0] io_pin_oe_out,
  // feedback into the array
  output      logic [pdroc_pkg::NUM_REGS-1:0]  reg_fb_out,
  output      logic [pdroc_pkg::NUM_CELLS-1:0] pin_fb_out
);

  import pdroc_pkg::*;

  // ========================================================
  // reset release
  logic [1:0]             rst_sync_reg;
  logic                   rst_n;

  // ========================================================
  // synchronised terms
  logic [NUM_REGS-1:0]    sum_s;
  logic [NUM_REGS-1:0]    clk_s;
  logic [NUM_REGS-1:0]    rst_s;
  logic                   preset_s;
  logic                   clk_pin_s;
  logic [NUM_CELLS-1:0]   oe_s;

  // ========================================================
  // configuration and state
  logic                   compat_reg;
  logic                   secure_reg;
  logic [NUM_REGS-1:0]    ttype_reg;
  logic [NUM_REGS-1:0]    pinclk_reg;
  logic [NUM_CELLS-1:0]   outsel_reg;
  logic [NUM_CELLS-1:0]   pol_reg;
  logic [NUM_REGS-1:0]    eff_ttype;
  logic [NUM_REGS-1:0]    eff_pinclk;
  logic [NUM_REGS-1:0]    q;
  pdroc_pwr_e             pwr_state_reg;
  logic [7:0]             pwr_cnt_reg;
  logic                   hold;

  // ========================================================
  // bus
  pdroc_apb_e             apb_state_reg;
  logic                   wr_fire;
  logic                   rd_hit;
  logic [31:0]            rd_next;

  // ========================================================
  // reset release: async assert, two flop release
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ========================================================
  // term synchronisers; terms arrive from outside this clock
  pdroc_sync #(.WIDTH(NUM_REGS)) u_sync_sum (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .d_in     (sum_term_in),
    .q_out    (sum_s)
  );

  pdroc_sync #(.WIDTH(NUM_REGS)) u_sync_clk (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .d_in     (clk_term_in),
    .q_out    (clk_s)
  );

  pdroc_sync #(.WIDTH(NUM_REGS)) u_sync_rst (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .d_in     (rst_term_in),
    .q_out    (rst_s)
  );

  // preset and pin clock travel together so the preset meets its edge
  pdroc_sync #(.WIDTH(2)) u_sync_shared (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .d_in     ({preset_term_in, clk_pin_in}),
    .q_out    ({preset_s, clk_pin_s})
  );

  pdroc_sync #(.WIDTH(NUM_CELLS)) u_sync_oe (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .d_in     (oe_term_in),
    .q_out    (oe_s)
  );

  // dedicated pin input path, apart from register feedback
  pdroc_sync #(.WIDTH(NUM_CELLS)) u_sync_pin (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .d_in     (io_pin_in),
    .q_out    (pin_fb_out)
  );

  // ========================================================
  // power-up hold: registers kept low until the delay ends
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state_reg <= PWR_HOLD;
      pwr_cnt_reg   <= 8'h00;
    end else begin
      case (pwr_state_reg)
        PWR_HOLD: begin
          if (pwr_cnt_reg == 8'(PWRUP_CYC - 1)) begin
            pwr_state_reg <= PWR_RUN;
          end else begin
            pwr_cnt_reg <= pwr_cnt_reg + 8'h01;
          end
        end
        PWR_RUN: begin
          pwr_state_reg <= PWR_RUN;
        end
        default: begin
          pwr_state_reg <= PWR_HOLD;
        end
      endcase
    end
  end

  assign hold = (pwr_state_reg != PWR_RUN);

  // ========================================================
  // apb slave: one wait state, answer on the second access cycle
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      apb_state_reg <= APB_IDLE;
    end else begin
      case (apb_state_reg)
        APB_IDLE: begin
          if (psel_in && penable_in) begin
            apb_state_reg <= APB_RESP;
          end
        end
        APB_RESP: begin
          apb_state_reg <= APB_IDLE;
        end
        default: begin
          apb_state_reg <= APB_IDLE;
        end
      endcase
    end
  end

  assign wr_fire = (apb_state_reg == APB_RESP) && psel_in && penable_in && pwrite_in;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= RDATA_RST;
    end else if (apb_state_reg == APB_IDLE && psel_in && penable_in) begin
      pready_out  <= 1'b1;
      pslverr_out <= !rd_hit;
      prdata_out  <= pwrite_in ? RDATA_RST : rd_next;
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // ========================================================
  // read mux; secured configuration reads as all programmed
  always_comb begin
    rd_next = RDATA_RST;
    rd_hit  = 1'b1;
    case (paddr_in)
      OFS_CTRL: begin
        rd_next[CTRL_COMPAT_BIT] = compat_reg;
        rd_next[CTRL_SECURE_BIT] = secure_reg;
        rd_next[CTRL_READY_BIT]  = !hold;
      end
      OFS_TTYPE: begin
        rd_next[NUM_REGS-1:0] = secure_reg ? '1 : ttype_reg;
      end
      OFS_PINCLK: begin
        rd_next[NUM_REGS-1:0] = secure_reg ? '1 : pinclk_reg;
      end
      OFS_OUTSEL: begin
        rd_next[NUM_CELLS-1:0] = secure_reg ? '1 : outsel_reg;
      end
      OFS_POLARITY: begin
        rd_next[NUM_CELLS-1:0] = secure_reg ? '1 : pol_reg;
      end
      OFS_STATE: begin
        rd_next[NUM_REGS-1:0] = q;
      end
      OFS_PINS: begin
        rd_next[NUM_CELLS-1:0] = pin_fb_out;
      end
      OFS_OE: begin
        rd_next[NUM_CELLS-1:0] = io_pin_oe_out;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ========================================================
  // control: security bit is set-only until reset
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      compat_reg <= 1'b0;
      secure_reg <= 1'b0;
    end else if (wr_fire && paddr_in == OFS_CTRL) begin
      compat_reg <= pwdata_in[CTRL_COMPAT_BIT];
      secure_reg <= secure_reg | pwdata_in[CTRL_SECURE_BIT];
    end
  end

  // register type and clock source choices
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ttype_reg  <= TTYPE_RST;
      pinclk_reg <= PINCLK_RST;
    end else if (wr_fire) begin
      if (paddr_in == OFS_TTYPE) begin
        ttype_reg <= pwdata_in[NUM_REGS-1:0];
      end
      if (paddr_in == OFS_PINCLK) begin
        pinclk_reg <= pwdata_in[NUM_REGS-1:0];
      end
    end
  end

  // pin driver choice and output polarity per cell
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      outsel_reg <= OUTSEL_RST;
      pol_reg    <= POLARITY_RST;
    end else if (wr_fire) begin
      if (paddr_in == OFS_OUTSEL) begin
        outsel_reg <= pwdata_in[NUM_CELLS-1:0];
      end
      if (paddr_in == OFS_POLARITY) begin
        pol_reg <= pwdata_in[NUM_CELLS-1:0];
      end
    end
  end

  // compatibility mode masks the newer features, settings are kept
  assign eff_ttype  = compat_reg ? '0 : ttype_reg;
  assign eff_pinclk = compat_reg ? '0 : pinclk_reg;

  // ========================================================
  // twenty registers, each on private terms
  for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
    pdroc_flop u_flop (
      .clk_in         (sys_clk_in),
      .rst_n_in       (rst_n),
      .sum_in         (sum_s[r]),
      .clk_term_in    (clk_s[r]),
      .areset_in      (rst_s[r]),
      .clk_pin_in     (clk_pin_s),
      .preset_in      (preset_s),
      .hold_in        (hold),
      .pin_clk_sel_in (eff_pinclk[r]),
      .toggle_sel_in  (eff_ttype[r]),
      .q_out          (q[r])
    );
  end

  // every register feeds back, buried or not
  assign reg_fb_out = q;

  // ========================================================
  // output cells: one of two registers reaches the pin
  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        io_pin_out[c]    <= 1'b0;
        io_pin_oe_out[c] <= 1'b0;
      end else begin
        io_pin_out[c]    <= (outsel_reg[c] ? q[2*c+1] : q[2*c]) ^ pol_reg[c];
        io_pin_oe_out[c] <= oe_s[c];
      end
    end

    chk_pin_driver: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      1'b1 |=> io_pin_out[c] == (($past(outsel_reg[c]) ? $past(q[2*c+1])
                                  : $past(q[2*c])) ^ $past(pol_reg[c])))
      else $error("pin driven by wrong register");

    chk_oe_follow: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      ##3 io_pin_oe_out[c] == $past(oe_term_in[c], 3))
      else $error("output enable not following its term");
  end

  // ========================================================
  // checks
  chk_secure_readback: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (pready_out && secure_reg && !pwrite_in && paddr_in == OFS_TTYPE)
      |-> prdata_out == 32'h000F_FFFF)
    else $error("secured configuration visible");

  chk_compat_masks: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (compat_reg && clk_s == '0 && rst_s == '0 && !hold) |=> $stable(reg_fb_out))
    else $error("compatibility mode leaks new features");

  chk_powerup_low: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (pwr_state_reg == PWR_HOLD) |=> reg_fb_out == '0)
    else $error("register high during power-up hold");

  chk_powerup_len: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    $rose(rst_n) |-> hold [*8] ##1 hold ##1 hold ##1 !hold)
    else $error("power-up hold length wrong");

  chk_pin_path: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    ##2 pin_fb_out == $past(io_pin_in, 2))
    else $error("pin input path broken");

endmodule : pdroc_top

// [tb/pdroc_board.sv]
`timescale 1ns/100ps
// ==========================================================
// board logic driving the array terms and the io pins
module pdroc_board
  import pdroc_pkg::*;
(
  // system
  input  wire logic                            clk_in,
  // pin drive from the block
  input  wire logic [pdroc_pkg::NUM_CELLS-1:0] pin_out_in,
  input  wire logic [pdroc_pkg::NUM_CELLS-1:0] pin_oe_in,
  // array terms
  output      logic [pdroc_pkg::NUM_REGS-1:0]  sum_out,
  output      logic [pdroc_pkg::NUM_REGS-1:0]  clk_term_out,
  output      logic [pdroc_pkg::NUM_REGS-1:0]  rst_term_out,
  output      logic                            preset_out,
  output      logic                            clk_pin_out,
  output      logic [pdroc_pkg::NUM_CELLS-1:0] oe_term_out,
  // resolved pin level
  output      logic [pdroc_pkg::NUM_CELLS-1:0] pin_level_out
);
  logic [NUM_CELLS-1:0] drive_reg;

  // the board drives a pin only where the block has let go of it
  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drive_reg);

  initial begin
    sum_out      = '0;
    clk_term_out = '0;
    rst_term_out = '0;
    preset_out   = 1'b0;
    clk_pin_out  = 1'b0;
    oe_term_out  = '0;
    drive_reg    = '0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_cyc

  // terms settle through the block's sync stages before any clock rises
  task automatic set_terms(input logic [19:0] sum, input logic [19:0] rst, input logic [9:0] oe,
                           input logic [9:0] drv);
    @(posedge clk_in);
    sum_out      <= sum;
    rst_term_out <= rst;
    oe_term_out  <= oe;
    drive_reg    <= drv;
    wait_cyc(3);
  endtask : set_terms

  // clock held high three cycles and low five, so sum is held past the late sample
  task automatic pulse(input logic [19:0] terms, input logic pin);
    @(posedge clk_in);
    clk_term_out <= terms;
    clk_pin_out  <= pin;
    wait_cyc(3);
    clk_term_out <= '0;
    clk_pin_out  <= 1'b0;
    wait_cyc(5);
  endtask : pulse

  task automatic preset_all();
    @(posedge clk_in);
    preset_out <= 1'b1;
    wait_cyc(2);
    pulse('1, 1'b0);
    preset_out <= 1'b0;
  endtask : preset_all
endmodule : pdroc_board

// [tb/pdroc_top_bench.sv]
`timescale 1ns/100ps
// ==========================================================
// self checking bench
module pdroc_top_bench;
  import pdroc_pkg::*;
  typedef struct {logic [19:0] ttype; logic [19:0] sum; logic [19:0] clk; logic [19:0] exp;} pdroc_row_s;

  logic                 clk;
  logic                 rst_n;
  logic [7:0]           paddr;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [NUM_REGS-1:0]  sum_t;
  logic [NUM_REGS-1:0]  clk_t;
  logic [NUM_REGS-1:0]  rst_t;
  logic                 preset_t;
  logic                 clk_pin;
  logic [NUM_CELLS-1:0] oe_t;
  logic [NUM_CELLS-1:0] pin_lvl;
  logic [NUM_CELLS-1:0] pin_out;
  logic [NUM_CELLS-1:0] pin_oe;
  logic [NUM_REGS-1:0]  reg_fb;
  logic [NUM_CELLS-1:0] pin_fb;
  int                   fails;
  int                   n_tests;
  pdroc_row_s           rows [4];

  pdroc_top dut (.sys_clk_in(clk), .rst_n_in(rst_n), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .sum_term_in(sum_t), .clk_term_in(clk_t),
    .rst_term_in(rst_t), .preset_term_in(preset_t), .clk_pin_in(clk_pin), .oe_term_in(oe_t),
    .io_pin_in(pin_lvl), .io_pin_out(pin_out), .io_pin_oe_out(pin_oe), .reg_fb_out(reg_fb),
    .pin_fb_out(pin_fb));

  pdroc_board board (.clk_in(clk), .pin_out_in(pin_out), .pin_oe_in(pin_oe), .sum_out(sum_t),
    .clk_term_out(clk_t), .rst_term_out(rst_t), .preset_out(preset_t), .clk_pin_out(clk_pin),
    .oe_term_out(oe_t), .pin_level_out(pin_lvl));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic results();
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic cmp_bits(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bits

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  // pready is sampled at the rising edge; the request stands until then
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      fails++;
      results();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    cmp_word(rd, exp);
    cmp_word({31'h0000_0000, err}, {31'h0000_0000, exp_err});
  endtask : rd_chk

  // ========================================================
  // main sequence
  initial begin
    rows[0] = '{20'h0_0000, 20'hF_FFFF, 20'hF_FFFF, 20'hF_FFFF};
    rows[1] = '{20'h0_0000, 20'h0_0000, 20'h0_03FF, 20'hF_FC00};
    rows[2] = '{20'hF_FFFF, 20'h0_F0F0, 20'hF_FFFF, 20'hF_0CF0};
    rows[3] = '{20'h0_000F, 20'h0_000F, 20'hF_FFFF, 20'h0_000F};
    fails = 0;
    n_tests = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (16) @(posedge clk);
    cmp_bits(reg_fb, 20'h0_0000);
    rd_chk(OFS_TTYPE, {12'h000, TTYPE_RST}, 1'b0);
    rd_chk(OFS_CTRL, 32'h0000_0004, 1'b0);
    rd_chk(8'h40, 32'h0000_0000, 1'b1);
    foreach (rows[i]) begin
      wr(OFS_TTYPE, {12'h000, rows[i].ttype});
      board.set_terms(rows[i].sum, 20'h0_0000, 10'h000, 10'h000);
      board.pulse(rows[i].clk, 1'b0);
      cmp_bits(reg_fb, rows[i].exp);
    end
    wr(OFS_OUTSEL, 32'h0000_0001);
    wr(OFS_POLARITY, 32'h0000_0002);
    board.set_terms(20'h0_0000, 20'h0_0000, 10'h155, 10'h0F0);
    board.wait_cyc(3);
    cmp_bits({10'h000, pin_out}, 20'h0_0001);
    cmp_bits({10'h000, pin_oe}, 20'h0_0155);
    cmp_bits({10'h000, pin_fb}, 20'h0_00A1);
    cmp_bits(reg_fb, 20'h0_000F);
    board.set_terms(20'hF_FFFF, 20'hF_FFFF, 10'h000, 10'h000);
    board.pulse(20'hF_FFFF, 1'b1);
    cmp_bits(reg_fb, 20'h0_0000);
    wr(OFS_TTYPE, 32'h0000_0000);
    wr(OFS_PINCLK, 32'h0000_0001);
    board.set_terms(20'hF_FFFF, 20'h0_0000, 10'h000, 10'h000);
    board.pulse(20'h0_0000, 1'b1);
    cmp_bits(reg_fb, 20'h0_0001);
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_TTYPE, 32'h000F_FFFF);
    board.set_terms(20'h0_0000, 20'h0_0000, 10'h000, 10'h000);
    board.pulse(20'h0_0000, 1'b1);
    cmp_bits(reg_fb, 20'h0_0001);
    board.set_terms(20'hF_FFFF, 20'h0_0000, 10'h000, 10'h000);
    board.pulse(20'hF_FFFF, 1'b0);
    cmp_bits(reg_fb, 20'hF_FFFF);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_TTYPE, 32'h0000_0000);
    wr(OFS_PINCLK, 32'h0000_0000);
    board.set_terms(20'h0_0000, 20'h0_0001, 10'h000, 10'h000);
    board.preset_all();
    cmp_bits(reg_fb, 20'hF_FFFE);
    wr(OFS_OUTSEL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0002);
    rd_chk(OFS_OUTSEL, 32'h0000_03FF, 1'b0);
    rd_chk(OFS_TTYPE, 32'h000F_FFFF, 1'b0);
    // mid-run reset: registers low, security and settings cleared
    rst_n <= 1'b0;
    board.wait_cyc(2);
    cmp_bits(reg_fb, 20'h0_0000);
    rst_n <= 1'b1;
    board.wait_cyc(16);
    cmp_bits(reg_fb, 20'h0_0000);
    rd_chk(OFS_CTRL, 32'h0000_0004, 1'b0);
    rd_chk(OFS_POLARITY, {22'h00_0000, POLARITY_RST}, 1'b0);
    results();
  end
endmodule : pdroc_top_bench
